// File: shared/txd_map.svh
// Register offsets, field positions, reset values and sizes of the download engine
`ifndef TXD_MAP_SVH
`define TXD_MAP_SVH

`define TXD_OFF_CONFIG 8'h00
`define TXD_OFF_COMMAND 8'h04
`define TXD_OFF_CUR_PTR 8'h08
`define TXD_OFF_POLL 8'h0C
`define TXD_OFF_START_LEVEL 8'h10
`define TXD_OFF_STATUS 8'h14
`define TXD_OFF_MASKS 8'h18

`define TXD_CFG_TX_EN 0
`define TXD_CFG_CONT 1

`define TXD_CMD_PAUSE 0
`define TXD_CMD_RESUME 1
`define TXD_CMD_PATH_RESET 2
`define TXD_CMD_DONE_ACK 3

`define TXD_STS_DONE 0
`define TXD_STS_STARVED 1
`define TXD_STS_PAUSED 2
`define TXD_STS_BUSY 3
`define TXD_STS_FIFO_LSB 16

`define TXD_MSK_IND 0
`define TXD_MSK_INT 1

`define TXD_DESC_NEXT 32'h0000_0000
`define TXD_DESC_HDR 32'h0000_0004
`define TXD_DESC_FRAG0 32'h0000_0008
`define TXD_DESC_FRAG_STEP 32'h0000_0008
`define TXD_DESC_LEN_OFS 32'h0000_0004

`define TXD_HDR_EMPTY_BIT 31
`define TXD_HDR_DONE_BIT 16
`define TXD_HDR_NOTIFY_BIT 15
`define TXD_FRAG_LAST_BIT 31
`define TXD_FRAG_LEN_W 13

`define TXD_FIFO_DEPTH 10'h200
`define TXD_FIFO_AW 9
`define TXD_FIFO_CW 10

`define TXD_RST_START_LEVEL 16'h0200
`define TXD_RST_POLL 8'h00

`endif

// File: shared/txd_pkg.sv
// Types shared by the download engine and its transmit FIFO
`include "txd_map.svh"

package txd_pkg;

  typedef enum logic [13:0] {
    ST_IDLE = 14'h0001,
    ST_HDR_RD = 14'h0002,
    ST_HDR_PUSH = 14'h0004,
    ST_FRAG_ADDR_RD = 14'h0008,
    ST_FRAG_LEN_RD = 14'h0010,
    ST_SPACE_CHK = 14'h0020,
    ST_DATA_RD = 14'h0040,
    ST_DATA_PUSH = 14'h0080,
    ST_DONE_WR = 14'h0100,
    ST_PAUSE_WAIT = 14'h0200,
    ST_HDR_REREAD = 14'h0400,
    ST_NEXT_RD = 14'h0800,
    ST_POLL_WAIT = 14'h1000,
    ST_HALT = 14'h2000
  } txd_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } txd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } txd_apb_rsp_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } txd_bus_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } txd_bus_rsp_t;

  typedef struct packed {
    logic valid;
    logic single;
    logic eof;
    logic [15:0] data;
  } txd_mac_out_t;

  typedef struct packed {
    logic [511:0][8:0] mem;
    logic [`TXD_FIFO_AW-1:0] wr;
    logic [`TXD_FIFO_AW-1:0] rd;
    logic [`TXD_FIFO_CW-1:0] count;
    logic [`TXD_FIFO_CW-1:0] frames;
    logic underrun;
    txd_mac_out_t mac;
  } txd_fifo_st_t;

  typedef struct packed {
    txd_state_t state;
    logic [31:0] ptr;
    logic [31:0] hdr;
    logic [31:0] frag_off;
    logic [31:0] frag_addr;
    logic [`TXD_FRAG_LEN_W-1:0] frag_len;
    logic frag_last;
    logic [31:0] word;
    logic [1:0] bidx;
    logic [2:0] bcnt;
    logic [7:0] timer;
    logic pause;
    logic done;
    logic starved;
    logic cfg_tx_en;
    logic cfg_cont;
    logic [7:0] poll;
    logic [15:0] level;
    logic ind_mask;
    logic int_mask;
    logic [31:0] bus_addr;
    logic [31:0] bus_wdata;
    logic apb_ready;
    logic apb_err;
    logic [31:0] apb_rdata;
  } txd_eng_st_t;

endpackage

// File: verilog/txd_fifo.sv
// Byte-wide transmit FIFO that hands 2-byte words to the MAC transmitter
`timescale 1ns/1ps
`default_nettype none
`include "txd_map.svh"

module txd_fifo (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [7:0] i_push_byte,
  input wire logic i_push_eof,
  input wire logic i_mac_req,
  output var txd_pkg::txd_mac_out_t o_mac,
  output logic [`TXD_FIFO_CW-1:0] o_count,
  output logic [`TXD_FIFO_CW-1:0] o_frames,
  output logic o_underrun
);
  import txd_pkg::*;

  txd_fifo_st_t q;
  txd_fifo_st_t next_q;
  logic [8:0] rd0;
  logic [8:0] rd1;
  logic [1:0] pop;
  logic pop_eof;

  always_comb begin
    next_q = q;
    next_q.underrun = 1'b0;
    next_q.mac.valid = 1'b0;
    rd0 = q.mem[q.rd];
    rd1 = q.mem[q.rd + 9'h001];
    pop = 2'h0;
    pop_eof = 1'b0;
    if (i_mac_req) begin
      // A request with no complete word or frame end waiting is a starved transmitter
      if (q.count == 10'h000 || (q.count == 10'h001 && !rd0[8])) begin
        next_q.underrun = 1'b1;
      end else if (rd0[8]) begin
        pop = 2'h1;
        pop_eof = 1'b1;
        next_q.mac = '{valid: 1'b1, single: 1'b1, eof: 1'b1, data: {8'h00, rd0[7:0]}};
      end else begin
        pop = 2'h2;
        pop_eof = rd1[8];
        // Earlier byte sits in the low half and goes out first
        next_q.mac = '{valid: 1'b1, single: 1'b0, eof: rd1[8], data: {rd1[7:0], rd0[7:0]}};
      end
    end
    next_q.rd = q.rd + {7'h00, pop};
    if (i_push && q.count != `TXD_FIFO_DEPTH) begin
      next_q.mem[q.wr] = {i_push_eof, i_push_byte};
      next_q.wr = q.wr + 9'h001;
    end
    next_q.count = q.count + {9'h000, i_push && q.count != `TXD_FIFO_DEPTH} - {8'h00, pop};
    next_q.frames = q.frames + {9'h000, i_push && i_push_eof && q.count != `TXD_FIFO_DEPTH}
                    - {9'h000, pop_eof};
    if (i_flush) begin
      next_q.wr = '0;
      next_q.rd = '0;
      next_q.count = '0;
      next_q.frames = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_mac = q.mac;
  assign o_count = q.count;
  assign o_frames = q.frames;
  assign o_underrun = q.underrun;

endmodule
`default_nettype wire

// File: verilog/txd_engine.sv
// Descriptor-walking download engine with APB registers and transmit start control
//
// Contract
// - Start only with nonzero pointer, not paused
// - Fetch header; empty flag skips to next
// - Check FIFO space before each burst
// - Fetch fragment pointer/length, copy data in
// - Write done bit back after last fragment
// - Pause stops after descriptor until resume
// - Re-read header; notify sets masked done indication
// - Zero next pointer idles, waits host pointer
// - Polling re-fetches next pointer until nonzero
// - New pointer returns to pause check
// - Pack any-alignment bytes into full words
// - Words to MAC, earlier byte first, odd tail
// - Delimiters, check sequence, status added downstream
// - Start on whole frame or level exceeded
// - Start level above 512 means 512
// - Continuous select or wait for FIFO drain
// - MAC request on empty FIFO is underrun
// - Underrun sets starved flag, halts download
// - Pointer keeps underrun descriptor address
// - Path reset clears done and starved
// - Pointer writes accepted only when zero
// - Pause takes effect at descriptor boundary
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "txd_map.svh"

module txd_engine (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire txd_pkg::txd_apb_req_t i_apb,
  output var txd_pkg::txd_apb_rsp_t o_apb,
  output var txd_pkg::txd_bus_req_t o_bus,
  input wire txd_pkg::txd_bus_rsp_t i_bus,
  input wire logic i_mac_req,
  output var txd_pkg::txd_mac_out_t o_mac,
  output logic o_tx_go,
  output logic o_download_done_ind,
  output logic o_download_done_irq
);
  import txd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] burst_size(input logic [1:0] a,
                                            input logic [`TXD_FRAG_LEN_W-1:0] len);
    logic [2:0] room;
    room = 3'h4 - {1'b0, a};
    if (len < {10'h000, room}) begin
      burst_size = len[2:0];
    end else begin
      burst_size = room;
    end
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] idx);
    byte_of = w[{idx, 3'h0} +: 8];
  endfunction

  function automatic logic reg_hit(input logic [31:0] a);
    logic [7:0] o;
    o = a[7:0];
    reg_hit = (a[31:8] == 24'h000000) && (o == `TXD_OFF_CONFIG || o == `TXD_OFF_COMMAND ||
              o == `TXD_OFF_CUR_PTR || o == `TXD_OFF_POLL || o == `TXD_OFF_START_LEVEL ||
              o == `TXD_OFF_STATUS || o == `TXD_OFF_MASKS);
  endfunction

  localparam txd_eng_st_t ENG_RST = '{
    state: ST_IDLE, ptr: 32'h0000_0000, hdr: 32'h0000_0000, frag_off: 32'h0000_0000,
    frag_addr: 32'h0000_0000, frag_len: 13'h0000, frag_last: 1'b0, word: 32'h0000_0000,
    bidx: 2'h0, bcnt: 3'h0, timer: 8'h00, pause: 1'b0, done: 1'b0, starved: 1'b0,
    cfg_tx_en: 1'b0, cfg_cont: 1'b0, poll: `TXD_RST_POLL, level: `TXD_RST_START_LEVEL,
    ind_mask: 1'b0, int_mask: 1'b0, bus_addr: 32'h0000_0000, bus_wdata: 32'h0000_0000,
    apb_ready: 1'b0, apb_err: 1'b0, apb_rdata: 32'h0000_0000};

  txd_eng_st_t q;
  txd_eng_st_t next_q;
  logic push;
  logic [7:0] push_byte;
  logic push_eof;
  logic [`TXD_FIFO_CW-1:0] fifo_count;
  logic [`TXD_FIFO_CW-1:0] fifo_frames;
  logic [`TXD_FIFO_CW-1:0] fifo_free;
  logic fifo_underrun;
  logic req_on;
  logic apb_wr;
  logic [7:0] off;
  logic [3:0] cmd;
  logic [15:0] level_eff;

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO

  txd_fifo u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_flush(cmd[`TXD_CMD_PATH_RESET]),
    .i_push(push),
    .i_push_byte(push_byte),
    .i_push_eof(push_eof),
    .i_mac_req(i_mac_req),
    .o_mac(o_mac),
    .o_count(fifo_count),
    .o_frames(fifo_frames),
    .o_underrun(fifo_underrun)
  );

  assign fifo_free = `TXD_FIFO_DEPTH - fifo_count;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_q = q;
    push = 1'b0;
    push_byte = 8'h00;
    push_eof = 1'b0;
    off = i_apb.paddr[7:0];
    req_on = (q.state == ST_HDR_RD) || (q.state == ST_FRAG_ADDR_RD) ||
             (q.state == ST_FRAG_LEN_RD) || (q.state == ST_DATA_RD) ||
             (q.state == ST_DONE_WR) || (q.state == ST_HDR_REREAD) || (q.state == ST_NEXT_RD);
    apb_wr = i_apb.psel && i_apb.penable && q.apb_ready && i_apb.pwrite && !q.apb_err;
    cmd = (apb_wr && off == `TXD_OFF_COMMAND) ? i_apb.pwdata[3:0] : 4'h0;

    // Register access: no wait states, read data captured in the setup cycle
    next_q.apb_ready = i_apb.psel && !i_apb.penable;
    if (i_apb.psel && !i_apb.penable) begin
      next_q.apb_err = !reg_hit(i_apb.paddr);
      next_q.apb_rdata = 32'h0000_0000;
      if (!i_apb.pwrite) begin
        case (off)
          `TXD_OFF_CONFIG: begin
            next_q.apb_rdata[`TXD_CFG_TX_EN] = q.cfg_tx_en;
            next_q.apb_rdata[`TXD_CFG_CONT] = q.cfg_cont;
          end
          `TXD_OFF_CUR_PTR: next_q.apb_rdata = q.ptr;
          `TXD_OFF_POLL: next_q.apb_rdata[7:0] = q.poll;
          `TXD_OFF_START_LEVEL: next_q.apb_rdata[15:0] = q.level;
          `TXD_OFF_STATUS: begin
            next_q.apb_rdata[`TXD_STS_DONE] = q.done;
            next_q.apb_rdata[`TXD_STS_STARVED] = q.starved;
            next_q.apb_rdata[`TXD_STS_PAUSED] = q.pause &&
              (q.state == ST_IDLE || q.state == ST_PAUSE_WAIT);
            next_q.apb_rdata[`TXD_STS_BUSY] = (q.state != ST_IDLE);
            next_q.apb_rdata[`TXD_STS_FIFO_LSB +: `TXD_FIFO_CW] = fifo_count;
          end
          `TXD_OFF_MASKS: begin
            next_q.apb_rdata[`TXD_MSK_IND] = q.ind_mask;
            next_q.apb_rdata[`TXD_MSK_INT] = q.int_mask;
          end
          default: next_q.apb_rdata = 32'h0000_0000;
        endcase
      end
    end

    if (apb_wr) begin
      case (off)
        `TXD_OFF_CONFIG: begin
          next_q.cfg_tx_en = i_apb.pwdata[`TXD_CFG_TX_EN];
          next_q.cfg_cont = i_apb.pwdata[`TXD_CFG_CONT];
        end
        `TXD_OFF_CUR_PTR: begin
          // Guards against the host and the engine owning the list at once
          if (q.ptr == 32'h0000_0000) begin
            next_q.ptr = {i_apb.pwdata[31:3], 3'h0};
          end
        end
        `TXD_OFF_POLL: next_q.poll = i_apb.pwdata[7:0];
        `TXD_OFF_START_LEVEL: next_q.level = i_apb.pwdata[15:0];
        `TXD_OFF_MASKS: begin
          next_q.ind_mask = i_apb.pwdata[`TXD_MSK_IND];
          next_q.int_mask = i_apb.pwdata[`TXD_MSK_INT];
        end
        default: next_q.poll = q.poll;
      endcase
    end

    // Pause may be posted any time; the FSM only looks at it between descriptors
    if (cmd[`TXD_CMD_PAUSE]) begin
      next_q.pause = 1'b1;
    end else if (cmd[`TXD_CMD_RESUME]) begin
      next_q.pause = 1'b0;
    end
    if (cmd[`TXD_CMD_DONE_ACK]) begin
      next_q.done = 1'b0;
    end
    if (cmd[`TXD_CMD_PATH_RESET]) begin
      next_q.done = 1'b0;
      next_q.starved = 1'b0;
      next_q.ptr = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Descriptor walk

    case (q.state)
      ST_IDLE: begin
        if (q.ptr != 32'h0000_0000 && !q.pause && !q.starved && !cmd[`TXD_CMD_PATH_RESET] &&
            (q.cfg_cont || fifo_count == 10'h000)) begin
          next_q.state = ST_HDR_RD;
        end
      end
      ST_HDR_RD: begin
        if (i_bus.ack) begin
          next_q.hdr = i_bus.rdata;
          next_q.bidx = 2'h0;
          next_q.frag_off = `TXD_DESC_FRAG0;
          if (i_bus.rdata[`TXD_HDR_EMPTY_BIT]) begin
            next_q.state = ST_NEXT_RD;
          end else begin
            next_q.state = ST_HDR_PUSH;
          end
        end
      end
      ST_HDR_PUSH: begin
        if (fifo_count != `TXD_FIFO_DEPTH) begin
          push = 1'b1;
          push_byte = byte_of(q.hdr, q.bidx);
          next_q.bidx = q.bidx + 2'h1;
          if (q.bidx == 2'h3) begin
            next_q.state = ST_FRAG_ADDR_RD;
          end
        end
      end
      ST_FRAG_ADDR_RD: begin
        if (i_bus.ack) begin
          next_q.frag_addr = i_bus.rdata;
          next_q.state = ST_FRAG_LEN_RD;
        end
      end
      ST_FRAG_LEN_RD: begin
        if (i_bus.ack) begin
          next_q.frag_len = i_bus.rdata[`TXD_FRAG_LEN_W-1:0];
          next_q.frag_last = i_bus.rdata[`TXD_FRAG_LAST_BIT];
          next_q.frag_off = q.frag_off + `TXD_DESC_FRAG_STEP;
          if (i_bus.rdata[`TXD_FRAG_LEN_W-1:0] != 13'h0000) begin
            next_q.state = ST_SPACE_CHK;
          end else if (i_bus.rdata[`TXD_FRAG_LAST_BIT]) begin
            next_q.state = ST_DONE_WR;
          end else begin
            next_q.state = ST_FRAG_ADDR_RD;
          end
        end
      end
      ST_SPACE_CHK: begin
        // Burst never crosses a word, so a fetch always lands whole in the FIFO
        next_q.bcnt = burst_size(q.frag_addr[1:0], q.frag_len);
        if ({7'h00, burst_size(q.frag_addr[1:0], q.frag_len)} <= fifo_free) begin
          next_q.state = ST_DATA_RD;
        end
      end
      ST_DATA_RD: begin
        if (i_bus.ack) begin
          next_q.word = i_bus.rdata;
          next_q.bidx = q.frag_addr[1:0];
          next_q.state = ST_DATA_PUSH;
        end
      end
      ST_DATA_PUSH: begin
        // One byte a cycle: fragments of any alignment join without gaps
        push = 1'b1;
        push_byte = byte_of(q.word, q.bidx);
        push_eof = q.frag_last && q.frag_len == 13'h0001;
        next_q.bidx = q.bidx + 2'h1;
        next_q.frag_addr = q.frag_addr + 32'h0000_0001;
        next_q.frag_len = q.frag_len - 13'h0001;
        next_q.bcnt = q.bcnt - 3'h1;
        if (q.bcnt == 3'h1) begin
          if (q.frag_len != 13'h0001) begin
            next_q.state = ST_SPACE_CHK;
          end else if (q.frag_last) begin
            next_q.state = ST_DONE_WR;
          end else begin
            next_q.state = ST_FRAG_ADDR_RD;
          end
        end
      end
      ST_DONE_WR: begin
        if (i_bus.ack) begin
          next_q.state = ST_PAUSE_WAIT;
        end
      end
      ST_PAUSE_WAIT: begin
        if (!q.pause) begin
          next_q.state = ST_HDR_REREAD;
        end
      end
      ST_HDR_REREAD: begin
        if (i_bus.ack) begin
          if (i_bus.rdata[`TXD_HDR_NOTIFY_BIT]) begin
            next_q.done = 1'b1;
          end
          next_q.state = ST_NEXT_RD;
        end
      end
      ST_NEXT_RD: begin
        if (i_bus.ack) begin
          next_q.state = ST_IDLE;
          if (i_bus.rdata != 32'h0000_0000) begin
            next_q.ptr = {i_bus.rdata[31:3], 3'h0};
          end else if (q.poll != 8'h00) begin
            next_q.timer = q.poll;
            next_q.state = ST_POLL_WAIT;
          end else begin
            next_q.ptr = 32'h0000_0000;
          end
        end
      end
      ST_POLL_WAIT: begin
        next_q.timer = q.timer - 8'h01;
        if (q.timer == 8'h01) begin
          next_q.state = ST_NEXT_RD;
        end
      end
      ST_HALT: begin
        if (cmd[`TXD_CMD_PATH_RESET]) begin
          next_q.state = ST_IDLE;
        end
      end
      default: next_q.state = ST_IDLE;
    endcase

    // Starved transmitter: let an open bus cycle finish, then freeze with the pointer kept
    if (fifo_underrun) begin
      next_q.starved = 1'b1;
    end
    if (q.starved && q.state != ST_HALT && !(req_on && !i_bus.ack)) begin
      next_q.state = ST_HALT;
    end

    // Address and data for the cycle about to be requested
    case (next_q.state)
      ST_HDR_RD, ST_HDR_REREAD, ST_DONE_WR: next_q.bus_addr = next_q.ptr + `TXD_DESC_HDR;
      ST_FRAG_ADDR_RD: next_q.bus_addr = next_q.ptr + next_q.frag_off;
      ST_FRAG_LEN_RD: next_q.bus_addr = next_q.ptr + next_q.frag_off + `TXD_DESC_LEN_OFS;
      ST_DATA_RD: next_q.bus_addr = {next_q.frag_addr[31:2], 2'h0};
      ST_NEXT_RD: next_q.bus_addr = next_q.ptr + `TXD_DESC_NEXT;
      default: next_q.bus_addr = q.bus_addr;
    endcase
    next_q.bus_wdata = next_q.hdr | (32'h0000_0001 << `TXD_HDR_DONE_BIT);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= ENG_RST;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_apb = '{pready: q.apb_ready, pslverr: q.apb_err && q.apb_ready,
                   prdata: q.apb_rdata};
  assign o_bus = '{req: req_on, write: (q.state == ST_DONE_WR), addr: q.bus_addr,
                   wdata: q.bus_wdata};

  assign level_eff = (q.level > 16'h0200) ? 16'h0200 : q.level;
  // Frame trailer and delimiters are the MAC's job once it sees the eof word
  assign o_tx_go = q.cfg_tx_en && (fifo_frames != 10'h000 ||
                   {6'h00, fifo_count} > level_eff);

  assign o_download_done_ind = q.done && q.ind_mask;
  assign o_download_done_irq = q.done && q.ind_mask && q.int_mask;

endmodule
`default_nettype wire

// File: testbench/txd_engine_sva.sv
// Port-level assertions for the download engine
`timescale 1ns/1ps
`default_nettype none
module txd_engine_sva (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire txd_pkg::txd_apb_req_t i_apb,
  input wire txd_pkg::txd_apb_rsp_t o_apb,
  input wire txd_pkg::txd_bus_req_t o_bus,
  input wire txd_pkg::txd_bus_rsp_t i_bus,
  input wire logic i_mac_req,
  input wire txd_pkg::txd_mac_out_t o_mac,
  input wire logic o_tx_go,
  input wire logic o_download_done_ind,
  input wire logic o_download_done_irq
);
  import txd_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_apb_answer: assert property (
    i_apb.psel && !i_apb.penable |=> o_apb.pready) else $error("no ready after setup");
  a_ready_pulse: assert property (
    o_apb.pready |=> !o_apb.pready) else $error("ready held too long");
  a_slv_err: assert property (
    i_apb.psel && !i_apb.penable && i_apb.paddr[7:0] > 8'h18 |=> o_apb.pslverr)
    else $error("unmapped offset not refused");
  a_bus_hold: assert property (
    o_bus.req && !i_bus.ack |=> o_bus.req && $stable(o_bus.addr) && $stable(o_bus.write))
    else $error("memory request dropped or changed");
  a_done_wb: assert property (
    o_bus.req && o_bus.write |-> o_bus.addr[2:0] == 3'h4 && o_bus.wdata[16])
    else $error("write-back not a done header");
  a_mac_cause: assert property (
    o_mac.valid |-> $past(i_mac_req)) else $error("word without a request");
  a_tail_eof: assert property (
    o_mac.valid && o_mac.single |-> o_mac.eof) else $error("single byte not at frame end");
  a_irq_gate: assert property (
    o_download_done_irq |-> o_download_done_ind) else $error("irq without indication");
endmodule

bind txd_engine txd_engine_sva u_sva (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_apb(i_apb), .o_apb(o_apb), .o_bus(o_bus), .i_bus(i_bus), .i_mac_req(i_mac_req),
  .o_mac(o_mac), .o_tx_go(o_tx_go), .o_download_done_ind(o_download_done_ind),
  .o_download_done_irq(o_download_done_irq));
`default_nettype wire

// File: testbench/txd_host_mem.sv
// Host memory model behind the engine's bus-master port
`timescale 1ns/1ps
`default_nettype none
module txd_host_mem (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire txd_pkg::txd_bus_req_t i_bus,
  input wire logic [1:0] i_delay,
  output var txd_pkg::txd_bus_rsp_t o_bus
);
  import txd_pkg::*;
  logic [31:0] mem [0:255];
  logic [1:0] waited;
  // Plain always: the bench also loads descriptors straight into mem
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bus <= '0;
      waited <= 2'h0;
    end else if (i_bus.req && !o_bus.ack && waited == i_delay) begin
      o_bus.ack <= 1'b1;
      o_bus.rdata <= mem[i_bus.addr[9:2]];
      waited <= 2'h0;
      if (i_bus.write) begin
        mem[i_bus.addr[9:2]] <= i_bus.wdata;
      end
    end else begin
      o_bus.ack <= 1'b0;
      // Released data lines must not look like the last answer
      o_bus.rdata <= ~o_bus.rdata;
      waited <= (i_bus.req && !o_bus.ack) ? waited + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench: descriptor downloads, MAC drain, underrun and reset
`timescale 1ns/1ps
`default_nettype none
`include "txd_map.svh"
module tb_top;
  import txd_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_mac_req = 1'b0;
  logic [1:0] dly = 2'h0;
  txd_apb_req_t apb_q = '0;
  txd_apb_rsp_t apb_s;
  txd_bus_req_t bus_q;
  txd_bus_rsp_t bus_s;
  txd_mac_out_t mac;
  txd_mac_out_t mac_s;
  logic go, ind, irq, err;
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0001_1905;
  logic [31:0] rd;
  logic [7:0] exp_q [$];
  always #10 i_core_clk = ~i_core_clk;
  txd_engine dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_apb(apb_q), .o_apb(apb_s),
    .o_bus(bus_q), .i_bus(bus_s), .i_mac_req(i_mac_req), .o_mac(mac), .o_tx_go(go),
    .o_download_done_ind(ind), .o_download_done_irq(irq));
  txd_host_mem host (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_bus(bus_q),
    .i_delay(dly), .o_bus(bus_s));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {24'h0, a}, pwdata: d};
    @(posedge i_core_clk);
    apb_q.penable <= 1'b1;
    do begin
      // Response stands until the closing edge, so mid-cycle sampling avoids the edge race
      @(negedge i_core_clk);
      rdy = apb_s.pready;
      rd = apb_s.prdata;
      err = apb_s.pslverr;
      @(posedge i_core_clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    apb_q.psel <= 1'b0;
    apb_q.penable <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic pull();
    i_mac_req <= 1'b1;
    @(posedge i_core_clk);
    i_mac_req <= 1'b0;
    // The word stands for one cycle only; take it before the edge that clears it
    @(negedge i_core_clk);
    mac_s = mac;
    @(posedge i_core_clk);
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge i_core_clk);
    n_fail++;
    summarize();
  end
  initial begin
    int len0, len1, k;
    logic [31:0] hdr, a;
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int r = 0; r < 2; r++) begin
      a = rnd();
      dly <= a[1:0];
      for (k = 128; k < 256; k++) host.mem[k] = rnd();
      a = rnd();
      hdr = {16'h0000, 1'b1, a[14:0]};
      a = rnd();
      len0 = 3 - r;
      len1 = (r == 0) ? 2 * (a % 4) + 2 : a % 8 + 1;
      // Frame bytes are the four header bytes followed by the bytes of both host fragments
      host.mem[64] = 32'h0;
      host.mem[65] = hdr;
      host.mem[66] = 32'h0000_0201;
      host.mem[67] = len0;
      host.mem[68] = 32'h0000_0302;
      host.mem[69] = 32'h8000_0000 | len1;
      exp_q = {};
      for (k = 0; k < 4; k++) exp_q.push_back(hdr[8*k +: 8]);
      for (k = 0; k < len0 + len1; k++) begin
        a = (k < len0) ? 32'h201 + k : 32'h302 + k - len0;
        exp_q.push_back(host.mem[a[9:2]][8*a[1:0] +: 8]);
      end
      apb(1'b1, `TXD_OFF_CONFIG, {30'h0, r == 0, 1'b1});
      apb(1'b1, `TXD_OFF_MASKS, 32'h3);
      apb(1'b1, `TXD_OFF_START_LEVEL, 32'hFFFF);
      apb(1'b1, `TXD_OFF_COMMAND, 32'h1);
      apb(1'b1, `TXD_OFF_CUR_PTR, 32'h100);
      apb(1'b1, `TXD_OFF_CUR_PTR, 32'h180);
      apb(1'b0, `TXD_OFF_CUR_PTR, 32'h0);
      chk(rd, 32'h100);
      apb(1'b0, `TXD_OFF_STATUS, 32'h0);
      chk({28'h0, rd[3:0]}, 32'h4);
      apb(1'b1, `TXD_OFF_COMMAND, 32'h2);
      k = 0;
      while (ind !== 1'b1 && k < 3000) begin
        @(posedge i_core_clk);
        k++;
      end
      k = 0;
      do begin
        apb(1'b0, `TXD_OFF_STATUS, 32'h0);
        k++;
      end while (rd[3] !== 1'b0 && k < 500);
      chk({28'h0, rd[3:0]}, 32'h1);
      chk({30'h0, ind, irq}, 32'h3);
      chk(host.mem[65], hdr | 32'h0001_0000);
      apb(1'b0, `TXD_OFF_CUR_PTR, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, go}, 32'h1);
      for (k = 0; k < exp_q.size(); k += 2) begin
        pull();
        a = {13'h0, 1'b1, k + 2 >= exp_q.size(), k + 1 == exp_q.size(),
          (k + 1 < exp_q.size()) ? exp_q[k+1] : 8'h00, exp_q[k]};
        chk({13'h0, mac_s.valid, mac_s.eof, mac_s.single, mac_s.single ? 8'h00 : mac_s.data[15:8],
          mac_s.data[7:0]}, a);
      end
      pull();
      chk({31'h0, mac_s.valid}, 32'h0);
      apb(1'b0, `TXD_OFF_STATUS, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h3);
      if (r == 1) begin
        apb(1'b1, `TXD_OFF_COMMAND, 32'h8);
        apb(1'b0, `TXD_OFF_STATUS, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h2);
      end
      apb(1'b1, `TXD_OFF_COMMAND, 32'h4);
      apb(1'b0, `TXD_OFF_STATUS, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h0);
    end
    summarize();
  end
endmodule
`default_nettype wire
